// File: erase_engine.v
`timescale 1ns/100ps
`include "gate_regs.vh"
module erase_engine (
    input  wire mclk,
    input  wire rst_b,
    input  wire start,
    output reg  busy,
    output reg  done
);
    reg [`ERASE_CNT_W-1:0] cnt_q;
    always @(posedge mclk) begin
        if (!rst_b) begin
            cnt_q <= {`ERASE_CNT_W{1'b0}};
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy  <= 1'b1;
                cnt_q <= `ERASE_CYCLES;
            end else if (busy) begin
                if (cnt_q == 16'h0001) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end
endmodule // erase_engine

// File: flash_security_debug_gate.v
// Behaviour
// - on the first clock after reset releases, the security register is loaded from the configuration security byte.
// - field values 00, 01 and 11 mean secured, blocking debugger memory access but not control-word writes such as mass erase.
// - when unsecured all flash commands are accepted from debug port or processor.
// - while secured every debug memory access is blocked.
// - processor flash accesses are never gated by the security state.
// - while secured the debugger may set the mass erase bit, launching a full erase.
// - debugger mass erase proceeds even when regions are protected, if enabled.
// - with mass erase disabled, a debugger mass erase request stays pending until the enable is set.
// - debug offers register and memory access, run/halt, two breakpoints, two watchpoints.
// - serial wire debug is the only external debug interface.
// - after power-on reset the debug pins take their serial wire debug roles.
// - the probe drives the debug wire clock and debug logic runs from its edges.
// - the debug wire data pin is bidirectional, used for communication and control.
// - the mass erase bit clears itself once the erase completes.
// - a refused mass erase leaves the bit set until reset, or until the enable is set and that erase completes.
`timescale 1ns/100ps
`include "gate_regs.vh"
module flash_security_debug_gate (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire [7:0]  config_security_byte,
    input  wire        mass_erase_enable_field,
    input  wire        protect_any,
    input  wire        debug_wire_clk,
    input  wire        debug_wire_data_in,
    output reg         debug_wire_data_out,
    output reg         debug_wire_data_oe_b,
    output reg         pin_mux_swd,
    output reg  [1:0]  flash_security_register,
    output reg         secured,
    output reg         mem_req,
    output reg         mem_we,
    output reg  [31:0] mem_addr,
    output reg  [31:0] mem_wdata,
    input  wire [31:0] mem_rdata,
    input  wire        cpu_req,
    output reg         cpu_grant,
    output reg         mass_erase_busy,
    output reg         halt_req,
    output reg         debug_disable,
    output reg         sys_reset_req,
    output reg         core_hold,
    output reg  [1:0]  bkpt_hit_en,
    output reg  [1:0]  watch_en,
    output reg         mem_denied
);
    // -------------------------------------------------------------
    // pin sampling
    // -------------------------------------------------------------
    wire swclk_s;
    wire swdio_s;
    pin_sync u_clk_sync (
        .mclk (mclk),
        .rst_b(rst_b),
        .din  (debug_wire_clk),
        .dout (swclk_s)
    );
    pin_sync u_dio_sync (
        .mclk (mclk),
        .rst_b(rst_b),
        .din  (debug_wire_data_in),
        .dout (swdio_s)
    );
    reg  swclk_prev_q;
    wire swclk_rise = swclk_s & ~swclk_prev_q;
    wire swclk_fall = ~swclk_s & swclk_prev_q;

    // -------------------------------------------------------------
    // security state
    // -------------------------------------------------------------
    reg load_pending_q;
    wire sec_now = (flash_security_register != `SEC_UNSECURE);

    // -------------------------------------------------------------
    // link frame: ap, op, addr[31:0], then 32 data bits
    // header 1+1 bits, address 32 bits; read returns data on dio
    // simplified shifter, one bit in per clock rise, read data out one bit per clock fall
    // -------------------------------------------------------------
    reg  [5:0]  bit_cnt_q;
    reg  [33:0] hdr_q;
    reg  [31:0] data_q;
    reg  [5:0]  data_cnt_q;
    reg         in_data_q;
    reg         turn_q;
    reg  [7:0]  ctl_q;
    reg  [31:0] rd_shift_q;
    wire        hdr_ap = hdr_q[33];
    wire        hdr_wr = hdr_q[32];

    wire erase_start = ctl_q[`CTL_MASS_ERASE] & mass_erase_enable_field & ~mass_erase_busy;
    wire erase_busy;
    wire erase_done;
    reg  erase_launched_q;
    erase_engine u_erase (
        .mclk (mclk),
        .rst_b(rst_b),
        .start(erase_start & ~erase_launched_q),
        .busy (erase_busy),
        .done (erase_done)
    );

    always @(posedge mclk) begin
        if (!rst_b) begin
            swclk_prev_q            <= 1'b0;
            load_pending_q          <= 1'b1;
            flash_security_register <= 2'h0;
            secured                 <= 1'b1;
            pin_mux_swd             <= 1'b1;
            bit_cnt_q               <= 6'h00;
            hdr_q                   <= 34'h0;
            data_q                  <= 32'h0;
            data_cnt_q              <= 6'h00;
            in_data_q               <= 1'b0;
            turn_q                  <= 1'b0;
            ctl_q                   <= `CTL_RESET;
            rd_shift_q              <= 32'h0;
            erase_launched_q        <= 1'b0;
            debug_wire_data_out     <= 1'b0;
            debug_wire_data_oe_b    <= 1'b1;
            mem_req                 <= 1'b0;
            mem_we                  <= 1'b0;
            mem_addr                <= 32'h0;
            mem_wdata               <= 32'h0;
            mem_denied              <= 1'b0;
            cpu_grant               <= 1'b0;
            mass_erase_busy         <= 1'b0;
            halt_req                <= 1'b0;
            debug_disable           <= 1'b0;
            sys_reset_req           <= 1'b0;
            core_hold               <= 1'b0;
            bkpt_hit_en             <= 2'h0;
            watch_en                <= 2'h0;
        end else begin
            swclk_prev_q <= swclk_s;
            if (load_pending_q) begin
                flash_security_register <= config_security_byte[1:0];
                load_pending_q          <= 1'b0;
            end
            secured         <= load_pending_q | sec_now;
            cpu_grant       <= cpu_req;
            mass_erase_busy <= erase_busy;
            mem_req         <= 1'b0;
            mem_denied      <= 1'b0;
            if (erase_start)
                erase_launched_q <= 1'b1;
            if (erase_done) begin
                ctl_q[`CTL_MASS_ERASE] <= 1'b0;
                erase_launched_q       <= 1'b0;
            end
            halt_req      <= ctl_q[`CTL_DBG_REQ];
            debug_disable <= ctl_q[`CTL_DBG_DISABLE];
            sys_reset_req <= ctl_q[`CTL_SYS_RST_REQ];
            core_hold     <= ctl_q[`CTL_CORE_HOLD];
            bkpt_hit_en   <= ctl_q[6:5];
            watch_en      <= (secured || debug_disable) ? 2'h0 : ctl_q[6:5];
            if (swclk_rise && !turn_q) begin
                if (!in_data_q) begin
                    hdr_q     <= {hdr_q[32:0], swdio_s};
                    bit_cnt_q <= bit_cnt_q + 6'h01;
                    if (bit_cnt_q == 6'h21) begin
                        in_data_q  <= 1'b1;
                        data_cnt_q <= 6'h00;
                    end
                end else begin
                    data_q     <= {data_q[30:0], swdio_s};
                    data_cnt_q <= data_cnt_q + 6'h01;
                    if (data_cnt_q == 6'h1f) begin
                        in_data_q <= 1'b0;
                        bit_cnt_q <= 6'h00;
                        if (hdr_ap == `AP_CTL && hdr_wr) begin
                            // a refused erase keeps the bit up until reset, or until enabled and that erase completes
                            // last bit of the word is still on the pin, not in data_q
                            ctl_q[7:1] <= data_q[6:0];
                            if (swdio_s)
                                ctl_q[`CTL_MASS_ERASE] <= 1'b1;
                        end else if (hdr_ap == `AP_MEM) begin
                            if (secured) begin
                                mem_denied <= 1'b1;
                            end else begin
                                mem_req   <= 1'b1;
                                mem_we    <= hdr_wr;
                                mem_addr  <= hdr_q[31:0];
                                mem_wdata <= {data_q[30:0], swdio_s};
                            end
                        end
                        if (!hdr_wr) begin
                            turn_q     <= 1'b1;
                            data_cnt_q <= 6'h00;
                            if (hdr_ap == `AP_CTL)
                                rd_shift_q <= {24'h0, ctl_q};
                            else
                                rd_shift_q <= 32'h0;
                        end
                    end
                end
            end
            if (turn_q && mem_req && !mem_we)
                rd_shift_q <= mem_rdata;
            if (turn_q && swclk_fall) begin
                debug_wire_data_oe_b <= 1'b0;
                debug_wire_data_out  <= rd_shift_q[31];
                rd_shift_q           <= {rd_shift_q[30:0], 1'b0};
                data_cnt_q           <= data_cnt_q + 6'h01;
                if (data_cnt_q == 6'h20) begin
                    turn_q               <= 1'b0;
                    debug_wire_data_oe_b <= 1'b1;
                end
            end
        end
    end
endmodule // flash_security_debug_gate

// File: flash_security_debug_gate_asserts.sv
`timescale 1ns/100ps
`include "gate_regs.vh"
module gate_check (
    input wire       mclk,
    input wire       rst_b,
    input wire [7:0] config_security_byte,
    input wire       mass_erase_enable_field,
    input wire       debug_wire_data_oe_b,
    input wire       pin_mux_swd,
    input wire [1:0] flash_security_register,
    input wire       secured,
    input wire       mem_req,
    input wire       cpu_req,
    input wire       cpu_grant,
    input wire       mass_erase_busy,
    input wire       mem_denied
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // busy length counter, cleared by the idle cycles
    reg [15:0] busy_q;
    always @(posedge mclk) begin
        busy_q <= mass_erase_busy ? busy_q + 16'h1 : 16'h0;
    end
    sequence s_erase_start;
        $rose(mass_erase_busy);
    endsequence
    sequence s_load;
        rst_b && !$past(rst_b);
    endsequence
    a_reset_vals: assert property (disable iff (1'b0) !rst_b |=>
        secured && pin_mux_swd && debug_wire_data_oe_b) else $error("bad reset values");
    a_sec_load: assert property (s_load |=>
        flash_security_register == $past(config_security_byte[1:0])) else $error("no load");
    a_sec_hold: assert property (rst_b && $past(rst_b) && $past(rst_b, 2) |->
        $stable(flash_security_register)) else $error("field moved");
    a_sec_decode: assert property ($past(rst_b, 2) |->
        secured == (flash_security_register != `SEC_UNSECURE)) else $error("bad decode");
    a_mem_block: assert property (secured |-> !mem_req) else $error("mem leak");
    a_deny_only: assert property (mem_denied |-> secured) else $error("bad deny");
    a_cpu_free: assert property (cpu_req |=> cpu_grant) else $error("cpu gated");
    a_erase_en: assert property (s_erase_start |->
        mass_erase_enable_field) else $error("erase while off");
    a_erase_bound: assert property (mass_erase_busy |->
        busy_q < `ERASE_CYCLES) else $error("erase too long");
    a_erase_len: assert property ($fell(mass_erase_busy) |->
        busy_q == `ERASE_CYCLES) else $error("erase length");
endmodule // gate_check

bind flash_security_debug_gate gate_check i_gate_check (.mclk(mclk), .rst_b(rst_b),
    .config_security_byte(config_security_byte), .pin_mux_swd(pin_mux_swd),
    .mass_erase_enable_field(mass_erase_enable_field), .secured(secured),
    .debug_wire_data_oe_b(debug_wire_data_oe_b), .mem_req(mem_req), .cpu_req(cpu_req),
    .flash_security_register(flash_security_register), .cpu_grant(cpu_grant),
    .mass_erase_busy(mass_erase_busy), .mem_denied(mem_denied));

// File: gate_regs.vh
`ifndef GATE_REGS_VH
`define GATE_REGS_VH
// security field encodings
`define SEC_W              2
`define SEC_UNSECURE       2'h2
// debug control word layout, bit positions
`define CTL_MASS_ERASE     0
`define CTL_DBG_DISABLE    1
`define CTL_DBG_REQ        2
`define CTL_SYS_RST_REQ    3
`define CTL_CORE_HOLD      4
`define CTL_W              8
`define CTL_RESET          8'h00
// access port selection within a link frame
`define AP_MEM             1'b0
`define AP_CTL             1'b1
// link request opcodes
`define OP_READ            2'h0
`define OP_WRITE           2'h1
// counts
`define ERASE_CYCLES       16'h0100
`define ERASE_CNT_W        16
`define BKPT_NUM           2
`define WATCH_NUM          2
`define FRAME_BITS         6'h2a
`endif

// File: pin_sync.v
`timescale 1ns/100ps
module pin_sync (
    input  wire mclk,
    input  wire rst_b,
    input  wire din,
    output reg  dout
);
    reg meta_q;
    always @(posedge mclk) begin
        if (!rst_b) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // pin_sync

// File: probe_model.sv
`timescale 1ns/100ps
module probe_model (
    output reg clk_out,
    output reg dio_out,
    output reg dio_drv
);
    // clock parks low between frames, like the pin pull-down
    initial begin
        clk_out = 1'b0;
        dio_out = 1'b1;
        dio_drv = 1'b0;
    end
    task send(input ap, input wr, input [31:0] addr, input [31:0] data);
        reg [65:0] f;
        integer    i;
        begin
            f = {ap, wr, addr, data};
            dio_drv = 1'b1;
            for (i = 65; i >= 0; i = i - 1) begin
                dio_out = f[i];
                #200 clk_out = 1'b1;
                #200 clk_out = 1'b0;
            end
            dio_drv = 1'b0;
        end
    endtask
endmodule // probe_model

// File: test_flash_security_debug_gate.sv
`timescale 1ns/100ps
module test_flash_security_debug_gate;
    reg         mclk, rst_b, me_en, prot, cpu_req;
    reg  [7:0]  cfg;
    reg  [31:0] rdata;
    wire        sclk, pdo, pdrv, dout, oe_b, mux, sec, mreq, mwe, busy, grant, denied;
    wire [1:0]  fsr;
    wire [31:0] maddr, mwdata;
    // released line floats high through the pull-up
    wire        dio = pdrv ? pdo : (!oe_b ? dout : 1'b1);
    integer     bad_count, n_checks, k;
    probe_model i_probe_model (.clk_out(sclk), .dio_out(pdo), .dio_drv(pdrv));
    flash_security_debug_gate i_flash_security_debug_gate (.mclk(mclk), .rst_b(rst_b),
        .config_security_byte(cfg), .mass_erase_enable_field(me_en), .protect_any(prot),
        .debug_wire_clk(sclk), .debug_wire_data_in(dio), .debug_wire_data_out(dout),
        .debug_wire_data_oe_b(oe_b), .pin_mux_swd(mux), .flash_security_register(fsr),
        .secured(sec), .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr), .mem_wdata(mwdata),
        .mem_rdata(rdata), .cpu_req(cpu_req), .cpu_grant(grant), .mass_erase_busy(busy),
        .halt_req(), .debug_disable(), .sys_reset_req(), .core_hold(), .bkpt_hit_en(),
        .watch_en(), .mem_denied(denied));
    always #25 mclk = ~mclk;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks=%0d bad=%0d", n_checks, bad_count);
            if (bad_count == 0 && n_checks > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    task do_reset(input [1:0] f);
        begin
            @(negedge mclk);
            cfg = {6'h00, f};
            rst_b = 1'b0;
            repeat (2) @(negedge mclk);
            chk({sec, mux, oe_b}, 32'h7);
            rst_b = 1'b1;
            repeat (3) @(negedge mclk);
            chk(fsr, f);
            chk(sec, f != 2'h2);
        end
    endtask
    task mem_frame(input ok);
        integer n;
        begin
            n = 0;
            fork
                i_probe_model.send(1'b0, 1'b1, 32'h2000_0010, 32'hcafe_0123);
                begin
                    while ((mreq | denied) !== 1'b1 && n < 700) begin
                        @(negedge mclk);
                        n = n + 1;
                    end
                    chk({mreq, denied}, {ok, !ok});
                    if (ok) chk({mwe, maddr[30:0]}, 32'ha000_0010);
                    if (ok) chk(mwdata, 32'hcafe_0123);
                end
            join
        end
    endtask
    task erase(input en);
        integer n, m;
        begin
            @(negedge mclk);
            me_en = en;
            n = 0;
            m = 0;
            fork
                i_probe_model.send(1'b1, 1'b1, 32'h0100_0004, 32'h0000_0001);
                begin
                    while (busy !== 1'b1 && n < 700) begin
                        @(negedge mclk);
                        n = n + 1;
                    end
                    while (busy === 1'b1 && m < 400) begin
                        @(negedge mclk);
                        m = m + 1;
                    end
                    chk(m, en ? 32'd256 : 32'd0);
                end
            join
            if (!en) begin
                me_en = 1'b1;
                n = 0;
                while (busy !== 1'b1 && n < 10) begin
                    @(negedge mclk);
                    n = n + 1;
                end
                chk(busy, 1'b1);
                while (busy === 1'b1 && m < 400) begin
                    @(negedge mclk);
                    m = m + 1;
                end
            end
            repeat (20) @(negedge mclk);
            chk(busy, 1'b0);
        end
    endtask
    task cpu_pass;
        begin
            @(negedge mclk);
            cpu_req = 1'b1;
            @(negedge mclk);
            chk(grant, 1'b1);
            cpu_req = 1'b0;
            @(negedge mclk);
            chk(grant, 1'b0);
        end
    endtask
    initial begin
        #1000000;
        bad_count = bad_count + 1;
        complete_run;
    end
    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        me_en = 1'b1;
        prot = 1'b1;
        cpu_req = 1'b0;
        cfg = 8'h00;
        rdata = 32'h0;
        bad_count = 0;
        n_checks = 0;
        do_reset(2'h2);
        mem_frame(1'b1);
        for (k = 0; k < 4; k = k + 1) begin
            if (k != 2) begin
                do_reset(k[1:0]);
                mem_frame(1'b0);
            end
        end
        cpu_pass;
        erase(1'b1);
        do_reset(2'h3);
        erase(1'b0);
        complete_run;
    end
endmodule // test_flash_security_debug_gate
